// ==== logic/tapc_pkg.sv ====
/*
  Package for the test access port controller: controller states,
  instruction codes, register widths and reset values.
  Assumes nothing of its surroundings.
*/
package tapc_pkg;

  // ------------------------------------------------------------------
  // widths and codes
  // ------------------------------------------------------------------
  localparam int          TAPC_IR_W          = 4;
  localparam int          TAPC_BSR_W         = 297;
  localparam int          TAPC_ID_W          = 32;
  localparam int          TAPC_RESET_TMS_N   = 5;
  localparam logic [3:0]  TAPC_IR_CAPTURE    = 4'h1;
  localparam logic [3:0]  TAPC_IR_EXTEST     = 4'h0;
  localparam logic [3:0]  TAPC_IR_SAMPLE     = 4'h1;
  localparam logic [3:0]  TAPC_IR_BYPASS     = 4'hF;
  // value used for the instruction output after reset (selects id register)
  localparam logic [3:0]  TAPC_IR_RESET      = 4'hE;
  // arbitrary identification value, not a real maker code
  localparam logic [31:0] TAPC_ID_VALUE      = 32'h0000_0001;

  // ------------------------------------------------------------------
  // controller states
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    TAPC_RESET,
    TAPC_IDLE,
    TAPC_SEL_DR,
    TAPC_CAP_DR,
    TAPC_SHIFT_DR,
    TAPC_EXIT1_DR,
    TAPC_PAUSE_DR,
    TAPC_EXIT2_DR,
    TAPC_UPD_DR,
    TAPC_SEL_IR,
    TAPC_CAP_IR,
    TAPC_SHIFT_IR,
    TAPC_EXIT1_IR,
    TAPC_PAUSE_IR,
    TAPC_EXIT2_IR,
    TAPC_UPD_IR
  } tapc_state_t;

  // data register selected by the current instruction
  typedef enum logic [1:0] {
    TAPC_DR_ID,
    TAPC_DR_BSR,
    TAPC_DR_BYP
  } tapc_dr_t;

endpackage

// ==== logic/tapc_bsr.sv ====
/*
  Boundary scan register: shift stage plus parallel update latch.
  Assumes control strobes come from the controller on the same test clock.
*/
`timescale 1ns/1ps
`default_nettype none

module tapc_bsr #(
  parameter int W = tapc_pkg::TAPC_BSR_W
) (
  input  wire logic         tck,
  input  wire logic         trst_n,
  input  wire logic         tlr,
  input  wire logic         capture,
  input  wire logic         shift,
  input  wire logic         update,
  input  wire logic         sin,
  input  wire logic [W-1:0] pins_in,
  output logic     [W-1:0] upd_q,
  output logic              sout
);
  import tapc_pkg::*;

  logic [W-1:0] shreg;

  assign sout = shreg[W-1];

  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      shreg <= '0;
    end else if (capture) begin
      shreg <= pins_in;
    end else if (shift) begin
      shreg <= {shreg[W-2:0], sin};
    end
  end

  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      upd_q <= '0;
    end else if (tlr) begin
      upd_q[W-1] <= 1'b0;
    end else if (update) begin
      upd_q <= shreg;
    end
  end

endmodule

`default_nettype wire

// ==== logic/tapc_top.sv ====
/*
  Sixteen-state test access port controller with instruction, bypass,
  identification and boundary scan registers.
  Assumes the test master drives tck, tms, tdi and trst_n; the core side
  on mclk observes synchronised copies of the instruction and the extest
  flag only; the boundary outputs are registered on tck, not mclk.
*/
`timescale 1ns/1ps
`default_nettype none

module tapc_top #(
  parameter int BSR_W = tapc_pkg::TAPC_BSR_W
) (
  input  wire logic                             mclk,
  input  wire logic                             rstn,
  input  wire logic                             tck,
  input  wire logic                             trst_n,
  input  wire logic                             tms,
  input  wire logic                             tdi,
  output logic                                  tdo,
  output logic                                  tdo_oe,
  input  wire logic [BSR_W-1:0]                 bsr_pins_in,
  output logic     [BSR_W-1:0]                  bsr_pins_out,
  output logic     [tapc_pkg::TAPC_IR_W-1:0]    core_ir,
  output logic                                  core_extest
);
  import tapc_pkg::*;

  // ------------------------------------------------------------------
  // decoding helpers
  // ------------------------------------------------------------------
  function automatic tapc_dr_t dr_of(input logic [TAPC_IR_W-1:0] code);
    if (code == TAPC_IR_EXTEST || code == TAPC_IR_SAMPLE) begin
      dr_of = TAPC_DR_BSR;
    end else if (code == TAPC_IR_BYPASS) begin
      dr_of = TAPC_DR_BYP;
    end else begin
      // reserved codes fall back to bypass so the chain stays one bit long
      dr_of = (code == TAPC_IR_RESET) ? TAPC_DR_ID : TAPC_DR_BYP;
    end
  endfunction

  // ------------------------------------------------------------------
  // controller state machine on tck
  // ------------------------------------------------------------------
  tapc_state_t state;
  tapc_state_t next_state;

  always_comb begin
    next_state = state;
    case (state)
      TAPC_RESET:    next_state = tms ? TAPC_RESET    : TAPC_IDLE;
      TAPC_IDLE:     next_state = tms ? TAPC_SEL_DR   : TAPC_IDLE;
      TAPC_SEL_DR:   next_state = tms ? TAPC_SEL_IR   : TAPC_CAP_DR;
      TAPC_CAP_DR:   next_state = tms ? TAPC_EXIT1_DR : TAPC_SHIFT_DR;
      TAPC_SHIFT_DR: next_state = tms ? TAPC_EXIT1_DR : TAPC_SHIFT_DR;
      TAPC_EXIT1_DR: next_state = tms ? TAPC_UPD_DR   : TAPC_PAUSE_DR;
      TAPC_PAUSE_DR: next_state = tms ? TAPC_EXIT2_DR : TAPC_PAUSE_DR;
      TAPC_EXIT2_DR: next_state = tms ? TAPC_UPD_DR   : TAPC_SHIFT_DR;
      TAPC_UPD_DR:   next_state = tms ? TAPC_SEL_DR   : TAPC_IDLE;
      TAPC_SEL_IR:   next_state = tms ? TAPC_RESET    : TAPC_CAP_IR;
      TAPC_CAP_IR:   next_state = tms ? TAPC_EXIT1_IR : TAPC_SHIFT_IR;
      TAPC_SHIFT_IR: next_state = tms ? TAPC_EXIT1_IR : TAPC_SHIFT_IR;
      TAPC_EXIT1_IR: next_state = tms ? TAPC_UPD_IR   : TAPC_PAUSE_IR;
      TAPC_PAUSE_IR: next_state = tms ? TAPC_EXIT2_IR : TAPC_PAUSE_IR;
      TAPC_EXIT2_IR: next_state = tms ? TAPC_UPD_IR   : TAPC_SHIFT_IR;
      TAPC_UPD_IR:   next_state = tms ? TAPC_SEL_DR   : TAPC_IDLE;
      default:       next_state = TAPC_RESET;
    endcase
  end

  // tms high for five edges reaches reset from any state via the graph
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      state <= TAPC_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ------------------------------------------------------------------
  // state decodes
  // ------------------------------------------------------------------
  wire in_tlr      = (state == TAPC_RESET);
  wire cap_dr      = (state == TAPC_CAP_DR);
  wire sh_dr       = (state == TAPC_SHIFT_DR);
  wire upd_dr      = (state == TAPC_UPD_DR);
  wire cap_ir      = (state == TAPC_CAP_IR);
  wire sh_ir       = (state == TAPC_SHIFT_IR);
  wire upd_ir      = (state == TAPC_UPD_IR);

  // ------------------------------------------------------------------
  // instruction register
  // ------------------------------------------------------------------
  logic [TAPC_IR_W-1:0] ir_sh;
  logic [TAPC_IR_W-1:0] ir;

  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      ir_sh <= TAPC_IR_CAPTURE;
    end else if (cap_ir) begin
      ir_sh <= TAPC_IR_CAPTURE;
    end else if (sh_ir) begin
      ir_sh <= {tdi, ir_sh[TAPC_IR_W-1:1]};
    end
  end

  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      ir <= TAPC_IR_RESET;
    end else if (in_tlr) begin
      ir <= TAPC_IR_RESET;
    end else if (upd_ir) begin
      ir <= ir_sh;
    end
  end

  wire tapc_dr_t sel_dr = dr_of(ir);

  // value the instruction takes at the coming tck edge, seen by the crossing
  logic [TAPC_IR_W-1:0] next_ir;

  assign next_ir = in_tlr ? TAPC_IR_RESET : (upd_ir ? ir_sh : ir);

  // ------------------------------------------------------------------
  // bypass and identification registers
  // ------------------------------------------------------------------
  logic                 byp;
  logic [TAPC_ID_W-1:0] id_sh;

  // other states (idle, pause, exits) leave them untouched
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      byp <= 1'b0;
    end else if (cap_dr && sel_dr == TAPC_DR_BYP) begin
      byp <= 1'b0;
    end else if (sh_dr && sel_dr == TAPC_DR_BYP) begin
      byp <= tdi;
    end
  end

  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      id_sh <= TAPC_ID_VALUE;
    end else if (cap_dr && sel_dr == TAPC_DR_ID) begin
      id_sh <= TAPC_ID_VALUE;
    end else if (sh_dr && sel_dr == TAPC_DR_ID) begin
      id_sh <= {tdi, id_sh[TAPC_ID_W-1:1]};
    end
  end

  // ------------------------------------------------------------------
  // boundary scan register
  // ------------------------------------------------------------------
  wire  bsr_sel = (sel_dr == TAPC_DR_BSR);
  logic bsr_sout;
  logic [BSR_W-1:0] bsr_q;
  logic [BSR_W-1:0] pins_s1;
  logic [BSR_W-1:0] pins_s2;

  // pins are asynchronous to tck; two stages cost two tck edges of
  // capture latency but keep a metastable pin out of the chain
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      pins_s1 <= '0;
      pins_s2 <= '0;
    end else begin
      pins_s1 <= bsr_pins_in;
      pins_s2 <= pins_s1;
    end
  end

  tapc_bsr #(.W(BSR_W)) u_bsr (
    .tck     (tck),
    .trst_n  (trst_n),
    .tlr     (in_tlr),
    .capture (cap_dr && bsr_sel),
    .shift   (sh_dr && bsr_sel),
    .update  (upd_dr && bsr_sel),
    .sin     (tdi),
    .pins_in (pins_s2),
    .upd_q   (bsr_q),
    .sout    (bsr_sout)
  );

  // ------------------------------------------------------------------
  // data-out on falling tck
  // ------------------------------------------------------------------
  wire dr_bit = (sel_dr == TAPC_DR_BSR) ? bsr_sout :
                (sel_dr == TAPC_DR_BYP) ? byp : id_sh[0];
  wire out_bit = sh_ir ? ir_sh[0] : dr_bit;

  always_ff @(negedge tck or negedge trst_n) begin
    if (!trst_n) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else begin
      tdo    <= out_bit;
      tdo_oe <= sh_dr || sh_ir;
    end
  end

  // ------------------------------------------------------------------
  // boundary outputs on tck, held in a register straight from the latch
  // ------------------------------------------------------------------
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      bsr_pins_out <= '0;
    end else begin
      bsr_pins_out <= bsr_q;
    end
  end

  // ------------------------------------------------------------------
  // crossing of the instruction into mclk
  // ------------------------------------------------------------------
  // the copy moves on the same tck edge as the instruction, so the core
  // sees it even when tck stops right after update-IR; only the core reset
  // clears it, so a test reset shows up as a change at the next tck edge
  // limitation: two changes closer than about three mclk periods may be
  // missed by the core side
  logic                 ir_tgl;
  logic [TAPC_IR_W-1:0] ir_hold;
  logic                 tgl_m1;
  logic                 tgl_m2;
  logic                 tgl_m3;
  wire                  ir_moves = (next_ir != ir_hold);

  always_ff @(posedge tck or negedge rstn) begin
    if (!rstn) begin
      ir_tgl  <= 1'b0;
      ir_hold <= TAPC_IR_RESET;
    end else if (ir_moves) begin
      ir_tgl  <= ~ir_tgl;
      ir_hold <= next_ir;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tgl_m1 <= 1'b0;
      tgl_m2 <= 1'b0;
      tgl_m3 <= 1'b0;
    end else begin
      tgl_m1 <= ir_tgl;
      tgl_m2 <= tgl_m1;
      tgl_m3 <= tgl_m2;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      core_ir     <= TAPC_IR_RESET;
      core_extest <= 1'b0;
    end else if (tgl_m2 != tgl_m3) begin
      core_ir     <= ir_hold;
      core_extest <= (ir_hold == TAPC_IR_EXTEST);
    end
  end

endmodule

`default_nettype wire

// ==== tb/tapc_top_chk.sv ====
/*
  Checker for the test access port controller, bound to tapc_top.
  Assumes it sees only the top ports; keeps its own copy of the state graph.
*/
`timescale 1ns/1ps
`default_nettype none

module tapc_top_chk
  import tapc_pkg::*;
#(
  parameter int BSR_W = TAPC_BSR_W
) (
  input wire logic                 mclk,
  input wire logic                 rstn,
  input wire logic                 tck,
  input wire logic                 trst_n,
  input wire logic                 tms,
  input wire logic                 tdi,
  input wire logic                 tdo,
  input wire logic                 tdo_oe,
  input wire logic [BSR_W-1:0]     bsr_pins_out,
  input wire logic [TAPC_IR_W-1:0] core_ir,
  input wire logic                 core_extest
);
  tapc_state_t st;
  tapc_state_t next_st;
  logic [1:0]  age;

  always_comb begin
    case (st)
      TAPC_RESET:    next_st = tms ? TAPC_RESET : TAPC_IDLE;
      TAPC_IDLE:     next_st = tms ? TAPC_SEL_DR : TAPC_IDLE;
      TAPC_SEL_DR:   next_st = tms ? TAPC_SEL_IR : TAPC_CAP_DR;
      TAPC_CAP_DR:   next_st = tms ? TAPC_EXIT1_DR : TAPC_SHIFT_DR;
      TAPC_SHIFT_DR: next_st = tms ? TAPC_EXIT1_DR : TAPC_SHIFT_DR;
      TAPC_EXIT1_DR: next_st = tms ? TAPC_UPD_DR : TAPC_PAUSE_DR;
      TAPC_PAUSE_DR: next_st = tms ? TAPC_EXIT2_DR : TAPC_PAUSE_DR;
      TAPC_EXIT2_DR: next_st = tms ? TAPC_UPD_DR : TAPC_SHIFT_DR;
      TAPC_UPD_DR:   next_st = tms ? TAPC_SEL_DR : TAPC_IDLE;
      TAPC_SEL_IR:   next_st = tms ? TAPC_RESET : TAPC_CAP_IR;
      TAPC_CAP_IR:   next_st = tms ? TAPC_EXIT1_IR : TAPC_SHIFT_IR;
      TAPC_SHIFT_IR: next_st = tms ? TAPC_EXIT1_IR : TAPC_SHIFT_IR;
      TAPC_EXIT1_IR: next_st = tms ? TAPC_UPD_IR : TAPC_PAUSE_IR;
      TAPC_PAUSE_IR: next_st = tms ? TAPC_EXIT2_IR : TAPC_PAUSE_IR;
      TAPC_EXIT2_IR: next_st = tms ? TAPC_UPD_IR : TAPC_SHIFT_IR;
      default:       next_st = tms ? TAPC_SEL_DR : TAPC_IDLE;
    endcase
  end

  // age keeps $past from reaching back across a test reset
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      st  <= TAPC_RESET;
      age <= 2'h0;
    end else begin
      st  <= next_st;
      age <= (age == 2'h3) ? age : age + 2'h1;
    end
  end

  oe_state_a: assert property (@(posedge tck) disable iff (!trst_n)
    tdo_oe == (st == TAPC_SHIFT_DR || st == TAPC_SHIFT_IR)) else $error("tdo_oe off its state");
  ir_capture_a: assert property (@(posedge tck) disable iff (!trst_n)
    st == TAPC_SHIFT_IR && $past(st) == TAPC_CAP_IR && !tms |-> tdo ##1 !tdo)
    else $error("captured instruction pattern wrong");
  byp_first_a: assert property (@(posedge tck) disable iff (!trst_n)
    st == TAPC_SHIFT_DR && $past(st) == TAPC_CAP_DR && core_ir == 4'hF |-> !tdo)
    else $error("bypass capture not zero");
  byp_pass_a: assert property (@(posedge tck) disable iff (!trst_n)
    st == TAPC_SHIFT_DR && $past(st) == TAPC_SHIFT_DR && core_ir == 4'hF |-> tdo == $past(tdi))
    else $error("bypass delay wrong");
  latch_hold_a: assert property (@(posedge tck) disable iff (!trst_n)
    age == 2'h3 && $changed(bsr_pins_out) |-> $past(st) inside {TAPC_UPD_DR, TAPC_RESET}
    || $past(st, 2) inside {TAPC_UPD_DR, TAPC_RESET}) else $error("boundary latch moved");
  top_clear_a: assert property (@(posedge tck) disable iff (!trst_n)
    (st == TAPC_RESET)[*3] |-> !bsr_pins_out[BSR_W-1]) else $error("top boundary bit set");
  extest_set_a: assert property (@(posedge mclk) disable iff (!rstn)
    (core_ir == 4'h0)[*2] |-> core_extest) else $error("extest flag missing");
  extest_clr_a: assert property (@(posedge mclk) disable iff (!rstn)
    (core_ir != 4'h0)[*2] |-> !core_extest) else $error("extest flag stray");
endmodule

bind tapc_top tapc_top_chk #(.BSR_W(BSR_W)) chk_i (
  .mclk(mclk), .rstn(rstn), .tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi),
  .tdo(tdo), .tdo_oe(tdo_oe), .bsr_pins_out(bsr_pins_out), .core_ir(core_ir),
  .core_extest(core_extest)
);

`default_nettype wire

// ==== tb/tapc_master.sv ====
/*
  Test master model: drives the test clock, mode-select, data-in and test reset.
  Assumes calls come one at a time; the test clock stands still between calls.
*/
`timescale 1ns/1ps
`default_nettype none

module tapc_master (
  output logic      tck,
  output logic      trst_n,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  initial begin
    tck    = 1'b0;
    trst_n = 1'b0;
    tms    = 1'b1;
    tdi    = 1'b0;
  end

  // one 6 ns test clock period; inputs move while tck is low
  task automatic step(input logic m, input logic d, output logic q);
    #1;
    tms = m;
    tdi = d;
    #2;
    q   = tdo;
    tck = 1'b1;
    #3;
    tck = 1'b0;
    tdi = ~d; // released line must not look like held data
  endtask

  task automatic treset;
    trst_n = 1'b0;
    #10;
    trst_n = 1'b1;
    #5;
  endtask
endmodule

`default_nettype wire

// ==== tb/tb.sv ====
/*
  Self-checking testbench for tapc_top.
  Assumes tapc_master drives the test port and the checker is bound in.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  import tapc_pkg::*;
  localparam int W = TAPC_BSR_W;
  logic         mclk, rstn, tck, trst_n, tms, tdi, tdo, tdo_oe, core_extest, b;
  logic [W-1:0] pins_in, pins_out, d, q, e;
  logic [3:0]   core_ir;
  int           n_mismatch, comparisons;

  tapc_top #(.BSR_W(W)) dut (.mclk(mclk), .rstn(rstn), .tck(tck), .trst_n(trst_n),
    .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .bsr_pins_in(pins_in),
    .bsr_pins_out(pins_out), .core_ir(core_ir), .core_extest(core_extest));
  tapc_master m (.tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo(tdo));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [W-1:0] ex, input logic [W-1:0] got);
    comparisons++;
    if (got !== ex) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic wait_ir(input logic [3:0] ex);
    int i;
    for (i = 0; i < 20 && core_ir !== ex; i++) @(negedge mclk);
    chk("core_ir", W'(ex), W'(core_ir));
    if (i == 20) begin
      n_mismatch++;
      close_out();
    end
  endtask

  // from idle: scan n bits, detour through pause after bit p, end in idle
  task automatic scan(input logic ir, input int n, input int p, input logic [W-1:0] din);
    m.step(1'b1, 1'b0, b);
    if (ir) m.step(1'b1, 1'b0, b);
    m.step(1'b0, 1'b0, b);
    m.step(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++) begin
      m.step(i == n - 1 || i == p, din[i], q[i]);
      if (i == p && i != n - 1) begin
        m.step(1'b0, 1'b0, b);
        m.step(1'b0, 1'b0, b);
        m.step(1'b1, 1'b0, b);
        m.step(1'b0, 1'b0, b);
      end
    end
    m.step(1'b1, 1'b0, b);
    m.step(1'b0, 1'b0, b);
  endtask

  task automatic t_ir(input logic [3:0] code, input int p);
    scan(1'b1, 4, p, W'(code));
    chk("ir capture", W'(4'h1), W'(q[3:0]));
    wait_ir(code);
  endtask

  task automatic t_reset_id;
    wait_ir(4'hE);
    chk("extest", '0, W'(core_extest));
    m.step(1'b0, 1'b0, b);
    scan(1'b0, 32, 99, '0);
    chk("id", W'(TAPC_ID_VALUE), W'(q[31:0]));
    $display("test reset_id done");
  endtask

  task automatic t_bypass(input logic [3:0] code);
    t_ir(code, 1);
    scan(1'b0, 8, 99, W'(8'hB2));
    chk("bypass", W'(8'h64), W'(q[7:0]));
    $display("test bypass %h done", code);
  endtask

  task automatic t_boundary;
    @(negedge mclk) pins_in = {99{3'b101}};
    t_ir(4'h1, 99);
    d = {99{3'b011}};
    scan(1'b0, W, 100, d);
    e = {<<{pins_in}};
    chk("capture", e, q);
    m.step(1'b0, 1'b0, b);
    m.step(1'b0, 1'b0, b);
    e = {<<{d}};
    chk("latch", e, pins_out);
    t_ir(4'h0, 99);
    repeat (2) @(negedge mclk);
    chk("extest", W'(1'b1), W'(core_extest));
    $display("test boundary done");
  endtask

  task automatic t_tms_reset;
    m.step(1'b1, 1'b0, b);
    m.step(1'b0, 1'b0, b);
    repeat (5) m.step(1'b1, 1'b0, b);
    chk("top bit set", W'(pins_in[W-1]), W'(pins_out[W-1]));
    repeat (3) m.step(1'b1, 1'b0, b);
    chk("top bit", '0, W'(pins_out[W-1]));
    wait_ir(4'hE);
    m.step(1'b0, 1'b0, b);
    $display("test tms_reset done");
  endtask

  task automatic t_trst;
    t_ir(4'h0, 99);
    m.step(1'b1, 1'b0, b);
    m.step(1'b0, 1'b0, b);
    m.step(1'b0, 1'b0, b);
    #1;
    chk("oe shift", W'(1'b1), W'(tdo_oe));
    m.treset();
    chk("oe reset", '0, W'(tdo_oe));
    m.step(1'b1, 1'b0, b);
    wait_ir(4'hE);
    chk("extest", '0, W'(core_extest));
    $display("test trst done");
  endtask

  initial begin
    rstn        = 1'b0;
    pins_in     = '0;
    n_mismatch  = 0;
    comparisons = 0;
    repeat (10) @(posedge mclk);
    @(negedge mclk) rstn = 1'b1;
    m.treset();
    t_reset_id();
    t_bypass(4'hF);
    t_bypass(4'h5);
    t_boundary();
    t_tms_reset();
    t_trst();
    close_out();
  end
endmodule

`default_nettype wire
